// [rtl/rx_map_pkg.sv]
// Purpose: Constants for the receive channel mapper of the primary audio port
// Assumes: 8-bit register port, 32-bit audio slots
// Notes:   Offsets are the register addresses seen on the register port
package rx_map_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_RX_OFFSET     = 8'h26;
    localparam logic [7:0] ADDR_RX_PIN_SELECT = 8'h27;
    localparam logic [7:0] ADDR_RX_CH1_MAP    = 8'h28;
    localparam logic [7:0] ADDR_RX_CH2_MAP    = 8'h29;
    // Values after reset
    localparam logic [4:0] RESET_RX_OFFSET    = 5'h00;
    localparam logic [7:0] RESET_PIN_SELECT   = 8'h00;
    localparam logic [5:0] RESET_CH1_MAP      = 6'h20;
    localparam logic [5:0] RESET_CH2_MAP      = 6'h21;
    // Field positions in a channel map register
    localparam int         MAP_ENABLE_BIT     = 5;
    localparam int         MAP_SLOT_MSB       = 4;
    localparam int         MAP_HALF_BIT       = 4;
    // Slot geometry
    localparam int         SLOT_BITS          = 32;
    localparam int         POS_BITS           = 11;
    localparam int         NUM_OUT_CH         = 2;
    // Frame formats on format_in
    typedef enum logic [1:0] {
        FMT_TDM = 2'b00,
        FMT_I2S = 2'b01,
        FMT_LJ  = 2'b10
    } format_t;
endpackage : rx_map_pkg

// [rtl/audio_rx_channel_mapper.sv]
// Purpose: Receive-side channel mapping of the primary audio serial port
// Assumes: Bit clock is the link clock; frame sync and data change on its falling edge
// Notes:   Config crosses bit by bit; software changes it only while the port is idle
`timescale 1ns/1ps

module audio_rx_channel_mapper (
    // System clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_write_in,
    output logic      [7:0]  reg_rdata_out,
    // Static frame format
    input  wire logic [1:0]  format_in,
    // Serial audio link
    input  wire logic        bit_clock_in,
    input  wire logic        frame_sync_in,
    input  wire logic        primary_data_in,
    input  wire logic        secondary_data_input_in,
    // DAC channel data
    output logic      [31:0] dac_ch1_data_out,
    output logic             dac_ch1_valid_out,
    output logic      [31:0] dac_ch2_data_out,
    output logic             dac_ch2_valid_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register file, system clock domain
    logic [4:0] rx_msb_slot_shift;                // Slot 0 MSB offset
    logic [7:0] rx_pin_select;                    // Per-channel pin choice
    logic [5:0] rx_channel1_map;                  // Enable and slot, channel 1
    logic [5:0] rx_channel2_map;                  // Enable and slot, channel 2
    logic [4:0] next_rx_msb_slot_shift;
    logic [7:0] next_rx_pin_select;
    logic [5:0] next_rx_channel1_map;
    logic [5:0] next_rx_channel2_map;
    logic [7:0] next_reg_rdata;

    // Decode writes and form read data
    always_comb begin
        next_rx_msb_slot_shift = rx_msb_slot_shift;
        next_rx_pin_select     = rx_pin_select;
        next_rx_channel1_map   = rx_channel1_map;
        next_rx_channel2_map   = rx_channel2_map;
        if (reg_write_in) begin
            unique case (reg_addr_in)
                rx_map_pkg::ADDR_RX_OFFSET:     next_rx_msb_slot_shift = reg_wdata_in[4:0];
                rx_map_pkg::ADDR_RX_PIN_SELECT: next_rx_pin_select     = reg_wdata_in;
                // Top two bits are dropped, not stored
                rx_map_pkg::ADDR_RX_CH1_MAP:    next_rx_channel1_map   = reg_wdata_in[5:0];
                rx_map_pkg::ADDR_RX_CH2_MAP:    next_rx_channel2_map   = reg_wdata_in[5:0];
                default:                        next_rx_pin_select     = rx_pin_select;
            endcase
        end
        // Unmapped addresses read zero; reserved bits read zero
        unique case (reg_addr_in)
            rx_map_pkg::ADDR_RX_OFFSET:     next_reg_rdata = {3'h0, rx_msb_slot_shift};
            rx_map_pkg::ADDR_RX_PIN_SELECT: next_reg_rdata = rx_pin_select;
            rx_map_pkg::ADDR_RX_CH1_MAP:    next_reg_rdata = {2'h0, rx_channel1_map};
            rx_map_pkg::ADDR_RX_CH2_MAP:    next_reg_rdata = {2'h0, rx_channel2_map};
            default:                        next_reg_rdata = 8'h00;
        endcase
    end

    // Register state, documented reset values
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_msb_slot_shift <= rx_map_pkg::RESET_RX_OFFSET;
            rx_pin_select     <= rx_map_pkg::RESET_PIN_SELECT;
            rx_channel1_map   <= rx_map_pkg::RESET_CH1_MAP;
            rx_channel2_map   <= rx_map_pkg::RESET_CH2_MAP;
            reg_rdata_out     <= 8'h00;
        end else begin
            rx_msb_slot_shift <= next_rx_msb_slot_shift;
            rx_pin_select     <= next_rx_pin_select;
            rx_channel1_map   <= next_rx_channel1_map;
            rx_channel2_map   <= next_rx_channel2_map;
            reg_rdata_out     <= next_reg_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration into the bit clock domain
    // Each bit is a quasi-static level; a change mid-frame may corrupt one word.
    localparam int CFG_W = 1 + 2 + 5 + 2 + 12;
    logic [CFG_W-1:0] cfg_src;                    // Source side, system domain
    logic [CFG_W-1:0] cfg_meta;                   // First stage, read by second only
    logic [CFG_W-1:0] cfg_link;                   // Safe copy in link domain
    logic             link_reset;                 // Reset seen in link domain
    logic [1:0]       link_fmt;
    logic [4:0]       link_shift;
    logic [1:0]       link_sel;
    logic [5:0]       link_map [rx_map_pkg::NUM_OUT_CH];

    always_comb begin
        cfg_src = {reset_in, format_in, rx_msb_slot_shift, rx_pin_select[1:0],
                   rx_channel2_map, rx_channel1_map};
    end

    // Two-flop synchroniser, runs on every rising bit clock edge
    always_ff @(posedge bit_clock_in) begin
        cfg_meta <= cfg_src;
        cfg_link <= cfg_meta;
    end

    always_comb begin
        {link_reset, link_fmt, link_shift, link_sel} = cfg_link[CFG_W-1:12];
        link_map[0] = cfg_link[5:0];
        link_map[1] = cfg_link[11:6];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame position tracking, link domain
    logic                                 prev_sync;   // Frame sync one edge ago
    logic                                 right_half;  // Second half of a stereo frame
    logic [rx_map_pkg::POS_BITS-1:0]      bit_count;   // Bits since half start
    logic                                 next_prev_sync;
    logic                                 next_right_half;
    logic [rx_map_pkg::POS_BITS-1:0]      next_bit_count;
    logic [rx_map_pkg::POS_BITS-1:0]      lead;        // Protocol delay plus offset
    logic [rx_map_pkg::POS_BITS-1:0]      slot_pos;    // Bit index past slot 0 MSB
    logic [rx_map_pkg::POS_BITS-1:0]      cur_count;   // Bits since half start, this edge
    logic                                 pos_valid;
    logic                                 rise;
    logic                                 fall;

    // Frame starts: TDM and left-justified on rising sync, I2S on falling; stereo halves start on either sync edge
    always_comb begin
        rise            = frame_sync_in && !prev_sync;
        fall            = !frame_sync_in && prev_sync;
        next_prev_sync  = frame_sync_in;
        next_right_half = right_half;
        cur_count       = bit_count;
        // The edge that sees the sync change is bit 0; the stored count would lag one bit
        if (link_fmt == rx_map_pkg::FMT_TDM) begin
            if (rise) begin
                cur_count       = '0;
                next_right_half = 1'b0;
            end
        end else if (rise || fall) begin
            cur_count       = '0;
            next_right_half = (link_fmt == rx_map_pkg::FMT_I2S) ? rise : fall;
        end
        next_bit_count  = cur_count + 1'b1;
        // I2S and TDM put the MSB one bit after the sync edge; offset adds more
        lead      = rx_map_pkg::POS_BITS'(link_shift) + ((link_fmt == rx_map_pkg::FMT_LJ) ? 11'd0 : 11'd1);
        pos_valid = (cur_count >= lead);
        slot_pos  = cur_count - lead;
    end

    always_ff @(posedge bit_clock_in) begin
        if (link_reset) begin
            prev_sync  <= 1'b0;
            right_half <= 1'b0;
            bit_count  <= '0;
        end else begin
            prev_sync  <= next_prev_sync;
            right_half <= next_right_half;
            bit_count  <= next_bit_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel slot capture and hand-off
    logic [31:0] held_word   [rx_map_pkg::NUM_OUT_CH];  // Stable until next toggle
    logic        word_toggle [rx_map_pkg::NUM_OUT_CH];  // Flips per captured word
    logic [2:0]  toggle_sync [rx_map_pkg::NUM_OUT_CH];  // Meta, stable, previous
    logic [31:0] dac_data    [rx_map_pkg::NUM_OUT_CH];
    logic        dac_valid   [rx_map_pkg::NUM_OUT_CH];

    for (genvar ch = 0; ch < rx_map_pkg::NUM_OUT_CH; ch++) begin : g_chan
        logic [31:0] shift_word;
        logic [31:0] next_shift_word;
        logic [31:0] next_held_word;
        logic        next_word_toggle;
        logic        data_bit;
        logic        in_slot;
        logic [4:0]  slot_field;
        logic [31:0] next_dac_data;
        logic        next_dac_valid;

        // Pick the slot and pin this channel listens to
        always_comb begin
            slot_field = link_map[ch][rx_map_pkg::MAP_SLOT_MSB:0];
            data_bit   = link_sel[ch] ? secondary_data_input_in : primary_data_in;
            if (link_fmt == rx_map_pkg::FMT_TDM) begin
                // TDM: field is the slot number directly
                in_slot = pos_valid && (slot_pos[10:5] == {1'b0, slot_field});
            end else begin
                // Stereo: high bit picks right half, low bits the slot
                // Half as of this edge, so a left-justified MSB on the sync edge lands in its own half
                in_slot = pos_valid && (next_right_half == slot_field[rx_map_pkg::MAP_HALF_BIT])
                          && (slot_pos[10:5] == {2'h0, slot_field[3:0]});
            end
            next_shift_word  = {shift_word[30:0], data_bit};
            next_held_word   = held_word[ch];
            next_word_toggle = word_toggle[ch];
            // Disabled channel discards its input
            if (in_slot && link_map[ch][rx_map_pkg::MAP_ENABLE_BIT] && (slot_pos[4:0] == 5'h1f)) begin
                next_held_word   = next_shift_word;
                next_word_toggle = !word_toggle[ch];
            end
        end

        always_ff @(posedge bit_clock_in) begin
            if (link_reset) begin
                shift_word       <= 32'h0000_0000;
                held_word[ch]    <= 32'h0000_0000;
                word_toggle[ch]  <= 1'b0;
            end else begin
                shift_word       <= next_shift_word;
                held_word[ch]    <= next_held_word;
                word_toggle[ch]  <= next_word_toggle;
            end
        end

        // Toggle edge in system domain; held word is quiet for a frame afterwards
        always_comb begin
            next_dac_valid = toggle_sync[ch][1] ^ toggle_sync[ch][2];
            next_dac_data  = next_dac_valid ? held_word[ch] : dac_data[ch];
        end

        always_ff @(posedge clk_in) begin
            if (reset_in) begin
                toggle_sync[ch] <= 3'h0;
                dac_data[ch]    <= 32'h0000_0000;
                dac_valid[ch]   <= 1'b0;
            end else begin
                toggle_sync[ch] <= {toggle_sync[ch][1:0], word_toggle[ch]};
                dac_data[ch]    <= next_dac_data;
                dac_valid[ch]   <= next_dac_valid;
            end
        end
    end

    // Outputs straight from flops
    always_comb begin
        dac_ch1_data_out  = dac_data[0];
        dac_ch1_valid_out = dac_valid[0];
        dac_ch2_data_out  = dac_data[1];
        dac_ch2_valid_out = dac_valid[1];
    end

endmodule : audio_rx_channel_mapper

// [tb/rx_map_monitor.sv]
// Purpose: Port assertions for the receive channel mapper
// Assumes: One clk_in domain, synchronous reset
// Notes:   Config is written only while the link is idle
`timescale 1ns/1ps
module rx_map_monitor (
    // Watched ports
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_write_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic [31:0] dac_ch1_data_out,
    input wire logic        dac_ch1_valid_out,
    input wire logic        dac_ch2_valid_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    logic en1; // Channel 1 enable as last written
    logic en2; // Channel 2 enable as last written
    // Mirror enables; reset leaves both channels on
    always_ff @(posedge clk_in) begin
        if (reset_in || (reg_write_in && reg_addr_in == 8'h28)) en1 <= reset_in | reg_wdata_in[5];
        if (reset_in || (reg_write_in && reg_addr_in == 8'h29)) en2 <= reset_in | reg_wdata_in[5];
    end
    ////////////////////////////////////////////////////////////
    AST_RESET_VALUES: assert property ($fell(reset_in) && !reg_write_in |=> reg_rdata_out ==
        ($past(reg_addr_in) == 8'h28 ? 8'h20 : ($past(reg_addr_in) == 8'h29 ? 8'h21 : 8'h00))) else $error("bad reset value");
    AST_PIN_READBACK: assert property ((reg_write_in && reg_addr_in == 8'h27) ##1
        (reg_addr_in == 8'h27 && !reg_write_in) |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("bad pin select");
    AST_MAP_READBACK: assert property ((reg_write_in && (reg_addr_in & 8'hfe) == 8'h28) ##1
        (reg_addr_in == $past(reg_addr_in) && !reg_write_in) |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h3f))
        else $error("bad map readback");
    AST_RESERVED_ZERO: assert property (($past(reg_addr_in) & 8'hfe) == 8'h28 |-> reg_rdata_out[7:6] == 2'b00)
        else $error("reserved bits set");
    AST_CH1_PULSE: assert property (dac_ch1_valid_out |=> !dac_ch1_valid_out)
        else $error("valid longer than one cycle");
    AST_CH1_HOLD: assert property ($changed(dac_ch1_data_out) |-> dac_ch1_valid_out)
        else $error("data changed without valid");
    AST_CH1_DISABLED: assert property (!en1 |-> !dac_ch1_valid_out)
        else $error("disabled channel 1 delivered");
    AST_CH2_DISABLED: assert property (!en2 |-> !dac_ch2_valid_out)
        else $error("disabled channel 2 delivered");
    // Main scenarios
    COV_CH1: cover property (dac_ch1_valid_out);
    COV_CH2: cover property (dac_ch2_valid_out);
    COV_OFF: cover property (!en1 && dac_ch2_valid_out);
endmodule : rx_map_monitor
bind audio_rx_channel_mapper rx_map_monitor rx_map_monitor_inst (.clk_in, .reset_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_rdata_out, .dac_ch1_data_out, .dac_ch1_valid_out, .dac_ch2_valid_out);

// [tb/audio_frame_source.sv]
// Purpose: Serial audio source facing the receive channel mapper
// Assumes: Sync and data change on the falling bit clock edge
// Notes:   Bit clock runs free so the receiver can leave reset
`timescale 1ns/1ps
module audio_frame_source (
    // Serial link
    output logic bit_clock_out,
    output logic frame_sync_out,
    output logic primary_data_out,
    output logic secondary_data_out
);
    logic busy; // High while a half frame is driven
    // 12 ns bit clock, phase unrelated to clk_in
    initial begin
        {busy, frame_sync_out, primary_data_out, secondary_data_out, bit_clock_out} = 5'h02;
        #3.7;
        forever #6 bit_clock_out = ~bit_clock_out;
    end
    // Idle pins toggle so no stale bit looks valid
    always @(negedge bit_clock_out) begin
        if (!busy) {primary_data_out, secondary_data_out} <= ~{primary_data_out, secondary_data_out};
    end
    // Slot word, unique per pin and slot
    function automatic logic [31:0] word(input logic pin, input int slot);
        return {pin ? 8'hc3 : 8'h3c, slot[7:0], 16'h96a5 ^ slot[15:0]};
    endfunction : word
    // Half frame: sync edge, offset padding, then n words MSB first on both pins
    task automatic send_half(input logic lvl, input logic pulse, input int off, input int base, input int n);
        logic [63:0] w;
        int          j;
        busy = 1'b1;
        for (int i = 0; i <= off + n * 32; i++) begin
            j = i - off - 1;
            if (j >= 0 && j % 32 == 0) w = {word(1'b0, base + j / 32), word(1'b1, base + j / 32)};
            @(negedge bit_clock_out);
            frame_sync_out <= (i == 0 || !pulse) ? lvl : 1'b0;
            {primary_data_out, secondary_data_out} <= (j >= 0) ? {w[63], w[31]} : ~{primary_data_out, secondary_data_out};
            if (j >= 0) w = w << 1;
        end
        // Let the last bit be sampled, then the idle toggler takes over the pins
        @(posedge bit_clock_out);
        busy = 1'b0;
    endtask : send_half
endmodule : audio_frame_source

// [tb/test_audio_rx_channel_mapper.sv]
// Purpose: Self-checking bench for the receive channel mapper
// Assumes: Inputs change on the falling clk_in edge
// Notes:   TDM, I2S and left-justified framing are each exercised
`timescale 1ns/1ps
module test_audio_rx_channel_mapper;
    logic        clk_in = 1'b0;        // 25 MHz system clock
    logic        reset_in = 1'b1;      // Held for 20 cycles
    logic [7:0]  reg_addr_in = 8'h27;  // Pin select seen at release
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_write_in = 1'b0;
    logic [1:0]  format_in = 2'b00;
    logic [7:0]  reg_rdata_out;
    logic        bclk, sync, pdat, sdat, v1, v2;
    logic [31:0] d1, d2, got1, got2;
    int          n1, n2, off, miscompares = 0, tests_run = 0, cycles = 0;
    // Cases: format, offset, pin select, channel 1 map, channel 2 map
    logic [39:0] cases [6] = '{40'h00_00_00_20_21, 40'h00_1f_03_3f_30, 40'h00_01_01_2f_01,
                               40'h00_02_fe_05_22, 40'h01_03_02_25_33, 40'h02_02_01_21_32};
    initial forever #20 clk_in = ~clk_in;
    audio_frame_source audio_frame_source_inst (.bit_clock_out(bclk), .frame_sync_out(sync),
        .primary_data_out(pdat), .secondary_data_out(sdat));
    audio_rx_channel_mapper audio_rx_channel_mapper_inst (.clk_in(clk_in), .reset_in(reset_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_rdata_out(reg_rdata_out), .format_in(format_in), .bit_clock_in(bclk), .frame_sync_in(sync),
        .primary_data_in(pdat), .secondary_data_input_in(sdat), .dac_ch1_data_out(d1),
        .dac_ch1_valid_out(v1), .dac_ch2_data_out(d2), .dac_ch2_valid_out(v2));
    // Collect delivered words; the cycle ceiling cuts a hang short
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (v1 === 1'b1) {got1, n1} <= {d1, n1 + 1};
        if (v2 === 1'b1) {got2, n2} <= {d2, n2 + 1};
        if (cycles == 6000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One write: strobe for one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        {reg_addr_in, reg_wdata_in, reg_write_in} = {a, d, 1'b1};
        @(negedge clk_in);
        reg_write_in = 1'b0;
    endtask : wr
    // Read data trails the address by one edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        reg_addr_in = a;
        @(negedge clk_in);
        check({24'h0, reg_rdata_out}, {24'h0, exp});
    endtask : rd
    task automatic wrap_up();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge clk_in);
        reset_in = 1'b0;
        rd(8'h27, 8'h00);
        rd(8'h28, 8'h20);
        rd(8'h29, 8'h21);
        wr(8'h29, 8'h3f); // Reserved bits written as zero
        rd(8'h29, 8'h3f);
        wr(8'h26, 8'hff);
        rd(8'h26, 8'h1f);
        wr(8'h27, 8'h5a);
        wr(8'h3a, 8'hff); // Unmapped write must change nothing
        rd(8'h27, 8'h5a);
        $display("test registers done");
        foreach (cases[i]) begin
            for (int r = 0; r < 4; r++) wr(8'h26 + 8'(r), cases[i][31 - 8 * r -: 8]);
            format_in = cases[i][33:32];
            {n1, n2} = '0;
            off = int'(cases[i][31:24]) - int'(cases[i][33]); // LJ MSB sits on the sync edge
            repeat (4) @(negedge clk_in);
            if (cases[i][33:32] != 2'b00) begin
                // LJ opens with the left half, I2S with the right half
                audio_frame_source_inst.send_half(1'b1, 1'b0, off, cases[i][33] ? 0 : 16, 16);
                audio_frame_source_inst.send_half(1'b0, 1'b0, off, cases[i][33] ? 16 : 0, 16);
            end else audio_frame_source_inst.send_half(1'b1, 1'b1, off, 0, 32);
            repeat (8) @(negedge clk_in);
            check(n1, {31'h0, cases[i][13]});
            check(n2, {31'h0, cases[i][5]});
            if (cases[i][13]) check(got1, audio_frame_source_inst.word(cases[i][16], int'(cases[i][12:8])));
            if (cases[i][5]) check(got2, audio_frame_source_inst.word(cases[i][17], int'(cases[i][4:0])));
            $display("test frame %0d done", i);
        end
        wrap_up();
    end
endmodule : test_audio_rx_channel_mapper
